// >>> logic/iep_pkg.sv
// Summary of operation
// RL1 - Each source is separately permitted or blocked by its own enable bit.
// RL2 - Global gate at 0 blocks every source regardless of enables.
// RL3 - Global gate at 1 lets a source request only when its enable is set.
// RL4 - Enable bit 1 permits its source, 0 blocks it.
// RL5 - Main enable register at A8h: gate, counter0, timer2, uart, timer1, pin1, timer0, pin0.
// RL6 - Aux enable register at A7h: adc, pins 6..2, counter1, expander port.
// RL7 - Both enables reset to zero; only the main one has single-bit access.
// RL8 - Each source gets one of four levels from two priority bits.
// RL9 - Low priority register gives the level LSB, high register the MSB.
// RL10 - High priority registers use the same bit positions as low ones.
// RL11 - A running routine is preempted by an enabled request of strictly higher level.
// RL12 - A request of equal level never preempts a running routine.
// RL13 - A routine at the top level is never preempted.
// RL14 - Among simultaneous requests the higher level is chosen.
// RL15 - Among simultaneous equal-level requests a fixed polling order chooses.
// RL16 - Level code 00 is lowest, 11 highest, others in between.
// RL17 - Polling order runs pin0, expander, pin2, timer0, ... timer2, pin6.
// RL18 - Polling order only breaks ties, never grants equal-level preemption.
// RL19 - A request competes only when flag, own enable and global gate are set.
package iep_pkg;
    // ========================================================================
    // Register indices, byte address is four times the index
    localparam logic [7:0] IEP_IDX_AUX_EN     = 8'hA7;
    localparam logic [7:0] IEP_IDX_MAIN_EN    = 8'hA8;
    localparam logic [7:0] IEP_IDX_PRIO_HI_AUX  = 8'hB5;
    localparam logic [7:0] IEP_IDX_PRIO_LO_AUX  = 8'hB6;
    localparam logic [7:0] IEP_IDX_PRIO_HI_MAIN = 8'hB7;
    localparam logic [7:0] IEP_IDX_PRIO_LO_MAIN = 8'hB8;
    localparam logic [7:0] IEP_IDX_MAIN_SET   = 8'hC0;
    localparam logic [7:0] IEP_IDX_MAIN_CLR   = 8'hC1;
    localparam logic [7:0] IEP_IDX_STATUS     = 8'hC2;
    // ========================================================================
    // Reset values and field positions
    localparam logic [7:0] IEP_EN_RESET       = 8'h00;
    localparam logic [7:0] IEP_PRIO_RESET     = 8'h00;
    localparam logic [7:0] IEP_MAIN_PRIO_MASK = 8'h7F;
    localparam int         IEP_GATE_BIT       = 7;
    localparam int         IEP_NUM_SRC        = 15;
    localparam int         IEP_NUM_LVL        = 4;
    // Main register bits
    localparam int IEP_M_PIN0 = 0;
    localparam int IEP_M_TMR0 = 1;
    localparam int IEP_M_PIN1 = 2;
    localparam int IEP_M_TMR1 = 3;
    localparam int IEP_M_UART = 4;
    localparam int IEP_M_TMR2 = 5;
    localparam int IEP_M_CNT0 = 6;
    // Aux register bits
    localparam int IEP_A_EXPP = 0;
    localparam int IEP_A_CNT1 = 1;
    localparam int IEP_A_PIN2 = 2;
    localparam int IEP_A_PIN3 = 3;
    localparam int IEP_A_PIN4 = 4;
    localparam int IEP_A_PIN5 = 5;
    localparam int IEP_A_PIN6 = 6;
    localparam int IEP_A_ADC  = 7;
endpackage : iep_pkg

// >>> logic/iep_ctrl.sv
`timescale 1ns/10ps
module iep_ctrl
    import iep_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [14:0] irq_flags,
    input  wire logic        cpu_vector_ack,
    input  wire logic        cpu_reti,
    output logic             irq_req,
    output logic      [3:0]  irq_src,
    output logic      [1:0]  irq_level
);
    // ========================================================================
    // State
    typedef struct packed {
        logic [7:0]  main_en;
        logic [7:0]  aux_en;
        logic [7:0]  prio_low_main;
        logic [7:0]  prio_low_aux;
        logic [7:0]  prio_high_main;
        logic [7:0]  prio_high_aux;
        logic [3:0]  in_service;
        logic        irq_req;
        logic [3:0]  irq_src;
        logic [1:0]  irq_level;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } iep_state_s;

    iep_state_s st;
    iep_state_s next_st;

    // ========================================================================
    // Register bits in polling order, index 0 polled first
    function automatic logic [14:0] iep_poll_map(input logic [7:0] m, input logic [7:0] a);
        logic [14:0] v;
        v[0]  = m[IEP_M_PIN0];
        v[1]  = a[IEP_A_EXPP];
        v[2]  = a[IEP_A_PIN2];
        v[3]  = m[IEP_M_TMR0];
        v[4]  = a[IEP_A_CNT1];
        v[5]  = a[IEP_A_PIN3];
        v[6]  = m[IEP_M_PIN1];
        v[7]  = a[IEP_A_ADC];
        v[8]  = a[IEP_A_PIN4];
        v[9]  = m[IEP_M_TMR1];
        v[10] = m[IEP_M_CNT0];
        v[11] = a[IEP_A_PIN5];
        v[12] = m[IEP_M_UART];
        v[13] = m[IEP_M_TMR2];
        v[14] = a[IEP_A_PIN6];
        return v;
    endfunction : iep_poll_map

    // ========================================================================
    // Gating and level decode
    logic [14:0] src_en;
    logic [14:0] eligible;
    logic [14:0] lvl_lo;
    logic [14:0] lvl_hi;
    logic [1:0]  src_lvl [15];

    assign src_en   = iep_poll_map(st.main_en, st.aux_en);                          // [RL1] [RL5] [RL6]
    assign eligible = irq_flags & src_en & {15{st.main_en[IEP_GATE_BIT]}};   // [RL2] [RL3] [RL4] [RL19]
    assign lvl_lo   = iep_poll_map(st.prio_low_main, st.prio_low_aux);                 // [RL10]
    assign lvl_hi   = iep_poll_map(st.prio_high_main, st.prio_high_aux);               // [RL10]

    genvar g;
    generate
        for (g = 0; g < IEP_NUM_SRC; g++) begin : g_lvl
            assign src_lvl[g] = {lvl_hi[g], lvl_lo[g]};                       // [RL8] [RL9] [RL16]
        end
    endgenerate

    // ========================================================================
    // Resolution
    logic       found;
    logic [3:0] best_idx;
    logic [1:0] best_lvl;
    logic       busy;
    logic [1:0] active_lvl;
    logic       may_preempt;

    always_comb begin
        found    = 1'b0;
        best_idx = 4'h0;
        best_lvl = 2'h0;
        // Downward scan so the earliest polled source wins a tie
        for (int i = IEP_NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!found || src_lvl[i] >= best_lvl)) begin    // [RL14] [RL15] [RL17]
                found    = 1'b1;
                best_idx = 4'(i);
                best_lvl = src_lvl[i];
            end
        end
    end

    always_comb begin
        busy       = |st.in_service;
        active_lvl = 2'h0;
        for (int l = 0; l < IEP_NUM_LVL; l++) begin
            if (st.in_service[l]) begin
                active_lvl = 2'(l);
            end
        end
        // Polling order plays no part here, only strict level compare
        may_preempt = !busy || (best_lvl > active_lvl);           // [RL11] [RL12] [RL13] [RL18]
    end

    // ========================================================================
    // APB decode
    logic [7:0]  idx;
    logic        acc_phase;
    logic        wr_now;
    logic        mapped;
    logic [31:0] rd_val;

    assign idx       = paddr[9:2];
    assign acc_phase = psel && penable;
    assign wr_now    = acc_phase && st.pready && pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            IEP_IDX_MAIN_EN, IEP_IDX_MAIN_SET, IEP_IDX_MAIN_CLR: rd_val[7:0] = st.main_en;
            IEP_IDX_AUX_EN:       rd_val[7:0] = st.aux_en;
            IEP_IDX_PRIO_LO_MAIN: rd_val[7:0] = st.prio_low_main;
            IEP_IDX_PRIO_LO_AUX:  rd_val[7:0] = st.prio_low_aux;
            IEP_IDX_PRIO_HI_MAIN: rd_val[7:0] = st.prio_high_main;
            IEP_IDX_PRIO_HI_AUX:  rd_val[7:0] = st.prio_high_aux;
            IEP_IDX_STATUS: rd_val[11:0] = {st.in_service, st.irq_req, st.irq_level,
                                            st.irq_src, 1'b0};
            default: mapped = 1'b0;
        endcase
    end

    // ========================================================================
    // Next state
    logic [3:0] isr_clr;

    always_comb begin
        next_st = st;
        // One wait state: answer is prepared, then presented
        next_st.pready  = acc_phase && !st.pready;
        next_st.pslverr = acc_phase && !st.pready && !mapped;
        if (acc_phase && !st.pready && !pwrite) begin
            next_st.prdata = rd_val;
        end
        if (wr_now) begin
            case (idx)
                IEP_IDX_MAIN_EN:      next_st.main_en = pwdata[7:0];                   // [RL5]
                IEP_IDX_MAIN_SET:     next_st.main_en = st.main_en | pwdata[7:0];      // [RL7]
                IEP_IDX_MAIN_CLR:     next_st.main_en = st.main_en & ~pwdata[7:0];     // [RL7]
                IEP_IDX_AUX_EN:       next_st.aux_en  = pwdata[7:0];                   // [RL6]
                IEP_IDX_PRIO_LO_MAIN: next_st.prio_low_main  = pwdata[7:0] & IEP_MAIN_PRIO_MASK;
                IEP_IDX_PRIO_LO_AUX:  next_st.prio_low_aux   = pwdata[7:0];
                IEP_IDX_PRIO_HI_MAIN: next_st.prio_high_main = pwdata[7:0] & IEP_MAIN_PRIO_MASK;
                IEP_IDX_PRIO_HI_AUX:  next_st.prio_high_aux  = pwdata[7:0];
                default: ;
            endcase
        end
        // Return clears the highest running level; a same-cycle vector wins
        isr_clr = 4'h0;
        if (cpu_reti && busy) begin
            isr_clr[active_lvl] = 1'b1;
        end
        next_st.in_service = st.in_service & ~isr_clr;
        if (cpu_vector_ack && st.irq_req) begin
            next_st.in_service[st.irq_level] = 1'b1;                          // [RL11]
        end
        // Request drops for the cycle after a vector so it is not taken twice
        next_st.irq_req   = found && may_preempt && !cpu_vector_ack;         // [RL12] [RL13]
        next_st.irq_src   = best_idx;
        next_st.irq_level = best_lvl;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st                <= '0;
            st.main_en        <= IEP_EN_RESET;                                 // [RL7]
            st.aux_en         <= IEP_EN_RESET;                                 // [RL7]
            st.prio_low_main  <= IEP_PRIO_RESET;
            st.prio_low_aux   <= IEP_PRIO_RESET;
            st.prio_high_main <= IEP_PRIO_RESET;
            st.prio_high_aux  <= IEP_PRIO_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata    = st.prdata;
    assign pready    = st.pready;
    assign pslverr   = st.pslverr;
    assign irq_req   = st.irq_req;
    assign irq_src   = st.irq_src;
    assign irq_level = st.irq_level;

    // ========================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Highest eligible level and any earlier-polled peer, for the checks
    logic [1:0]  chk_max_lvl;
    logic [14:0] chk_peer;
    always_comb begin
        chk_max_lvl = 2'h0;
        chk_peer    = 15'h0000;
        for (int k = 0; k < IEP_NUM_SRC; k++) begin
            if (eligible[k] && src_lvl[k] > chk_max_lvl) begin
                chk_max_lvl = src_lvl[k];
            end
        end
        for (int k = 0; k < IEP_NUM_SRC; k++) begin
            chk_peer[k] = eligible[k] && src_lvl[k] == best_lvl && 4'(k) < best_idx;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    a_gate_blocks: assert property (!st.main_en[IEP_GATE_BIT] |=> !irq_req)         // [RL2]
        else $error("request raised with global gate off");
    a_enable_needed: assert property (irq_req                                   // [RL19]
        |-> ($past(eligible) & (15'h0001 << irq_src)) != 15'h0000)
        else $error("request from a source that was not eligible");
    a_reset_zero: assert property ($fell(reset)                                 // [RL7]
        |-> st.main_en == 8'h00 && st.aux_en == 8'h00)
        else $error("enables not zero after reset");
    a_strict_preempt: assert property (irq_req && $past(busy)                   // [RL12]
                                       |-> irq_level > $past(active_lvl))
        else $error("preemption by equal or lower level");
    a_top_level: assert property (st.in_service[3] |=> !irq_req)               // [RL13]
        else $error("top level routine preempted");
    a_higher_wins: assert property (irq_req |-> irq_level == $past(chk_max_lvl))   // [RL14]
        else $error("lower level chosen over higher one");
    a_poll_order: assert property (irq_req |-> $past(chk_peer) == 15'h0000)     // [RL15]
        else $error("polling order not kept");
    a_prio_pair: assert property (irq_req |-> irq_level ==                      // [RL9]
        {|($past(lvl_hi) & (15'h0001 << irq_src)), |($past(lvl_lo) & (15'h0001 << irq_src))})
        else $error("level not built from high and low bits");
    a_main_write: assert property (s_access                                     // [RL5]
        ##0 (pready && pwrite && idx == IEP_IDX_MAIN_EN)
        |=> st.main_en == $past(pwdata[7:0]))
        else $error("main enable write lost");
    a_aux_write: assert property (s_access                                      // [RL6]
        ##0 (pready && pwrite && idx == IEP_IDX_AUX_EN)
        |=> st.aux_en == $past(pwdata[7:0]))
        else $error("aux enable write lost");

    // ========================================================================
    // Bus checks
    a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_refuse_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
        else $error("refused read without ready or with data");
    a_set_alias: assert property (s_access                                      // [RL7]
        ##0 (pready && pwrite && idx == IEP_IDX_MAIN_SET)
        |=> st.main_en == ($past(st.main_en) | $past(pwdata[7:0])))
        else $error("bit-set alias did not set enable bits");
    a_clr_alias: assert property (s_access                                      // [RL7]
        ##0 (pready && pwrite && idx == IEP_IDX_MAIN_CLR)
        |=> st.main_en == ($past(st.main_en) & ~$past(pwdata[7:0])))
        else $error("bit-clear alias did not clear enable bits");
    a_prio_reserved: assert property (((st.prio_low_main | st.prio_high_main) & ~IEP_MAIN_PRIO_MASK) == 8'h00)
        else $error("reserved main priority bit stored");

    // ========================================================================
    // Vectoring checks
    sequence s_vector;
        cpu_vector_ack && irq_req;
    endsequence

    // Idle with an eligible source must ask at the next edge
    a_gate_open: assert property ((|eligible) && !busy && !cpu_vector_ack |=> irq_req)  // [RL3]
        else $error("eligible request not raised while idle");
    a_vector_mark: assert property (s_vector                                    // [RL11]
        |=> (st.in_service & (4'h1 << $past(irq_level))) != 4'h0)
        else $error("vectored level not marked in service");
    a_vector_drop: assert property (s_vector |=> !irq_req)                      // [RL12]
        else $error("request not withdrawn after vector");
    a_top_code: assert property (irq_req && $past(st.in_service[2])             // [RL16]
        |-> irq_level == 2'h3)
        else $error("level above two not coded as highest");
    a_return_clear: assert property (cpu_reti && !cpu_vector_ack && busy
        |=> (st.in_service & (4'h1 << $past(active_lvl))) == 4'h0)
        else $error("return left highest level in service");
endmodule : iep_ctrl

// >>> verif/iep_cpu_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Core side: vectors a pending request after ack_wait cycles, forwards returns
module iep_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       irq_req,
    input  wire logic [3:0] irq_src,
    input  wire logic [1:0] irq_level,
    input  wire logic [3:0] ack_wait,
    input  wire logic       reti_cmd,
    output logic            cpu_vector_ack,
    output logic            cpu_reti,
    output logic      [3:0] taken_src,
    output logic      [1:0] taken_lvl,
    output logic      [7:0] taken_cnt
);
    logic [3:0] wait_cnt;

    always_ff @(posedge ref_clk) begin
        cpu_vector_ack <= 1'b0;
        cpu_reti       <= reti_cmd & ~reset;
        if (reset) begin
            wait_cnt  <= 4'h0;
            taken_src <= 4'h0;
            taken_lvl <= 2'h0;
            taken_cnt <= 8'h00;
        end else if (irq_req && !cpu_vector_ack) begin
            // Slow answer holds off the take while the request stands
            if (wait_cnt == ack_wait) begin
                cpu_vector_ack <= 1'b1;
                taken_src      <= irq_src;
                taken_lvl      <= irq_level;
                taken_cnt      <= taken_cnt + 8'h01;
                wait_cnt       <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : iep_cpu_model

// >>> verif/interrupt_enable_priority_tb.sv
`timescale 1ns/10ps
module interrupt_enable_priority_tb;
    import iep_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [14:0] irq_flags = 15'h0000;
    logic [3:0]  ack_wait = 4'h0;
    logic        reti_cmd = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq_req, ack, reti;
    logic [3:0]  irq_src, taken_src;
    logic [1:0]  irq_level, taken_lvl;
    logic [7:0]  taken_cnt;
    int          fails = 0;
    int          checked = 0;
    int          takes = 0;
    // Enable position per polling slot: bit 4 set means aux register
    logic [4:0]  pos [15] = '{5'h00, 5'h10, 5'h12, 5'h01, 5'h11, 5'h13, 5'h02, 5'h17,
                              5'h14, 5'h03, 5'h06, 5'h15, 5'h04, 5'h05, 5'h16};

    iep_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_flags(irq_flags), .cpu_vector_ack(ack), .cpu_reti(reti),
        .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level));
    iep_cpu_model cpu (.ref_clk(ref_clk), .reset(reset), .irq_req(irq_req),
        .irq_src(irq_src), .irq_level(irq_level), .ack_wait(ack_wait), .reti_cmd(reti_cmd),
        .cpu_vector_ack(ack), .cpu_reti(reti), .taken_src(taken_src),
        .taken_lvl(taken_lvl), .taken_cnt(taken_cnt));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ======================================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One wait state, so ready is seen at the second access edge
        chk("ready cycle", n, 32'd2);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic xerr);
        logic [31:0] d;
        logic        e;
        apb(1'b0, idx, 8'h00, d, e);
        chk("read data", d, exp);
        chk("read error", {31'h0, e}, {31'h0, xerr});
    endtask : rchk

    task automatic flags(input logic [14:0] v);
        @(posedge ref_clk);
        irq_flags <= v;
    endtask : flags

    task automatic ret();
        @(posedge ref_clk);
        reti_cmd <= 1'b1;
        @(posedge ref_clk);
        reti_cmd <= 1'b0;
    endtask : ret

    task automatic expect_take(input logic [3:0] src, input logic [1:0] lvl);
        int n;
        takes++;
        n = 0;
        while (taken_cnt != takes[7:0] && n < 30) begin
            @(posedge ref_clk);
            n++;
        end
        chk("take count", taken_cnt, takes[7:0]);
        chk("taken source", taken_src, src);
        chk("taken level", taken_lvl, lvl);
    endtask : expect_take

    task automatic expect_none();
        repeat (8) @(posedge ref_clk);
        chk("no take", taken_cnt, takes[7:0]);
    endtask : expect_none

    // ======================================================================
    // Scenarios
    task automatic t_regs();
        rchk(IEP_IDX_MAIN_EN, 32'h0, 1'b0);
        rchk(IEP_IDX_AUX_EN, 32'h0, 1'b0);
        rchk(IEP_IDX_PRIO_HI_AUX, 32'h0, 1'b0);
        rchk(8'h00, 32'h0, 1'b1);
        wr(IEP_IDX_AUX_EN, 8'hFF);
        rchk(IEP_IDX_AUX_EN, 32'hFF, 1'b0);
        wr(IEP_IDX_MAIN_SET, 8'h05);
        wr(IEP_IDX_MAIN_CLR, 8'h01);
        rchk(IEP_IDX_MAIN_EN, 32'h04, 1'b0);
        wr(IEP_IDX_AUX_EN, 8'h00);
        wr(IEP_IDX_MAIN_EN, 8'h00);
    endtask : t_regs

    task automatic t_gate();
        flags(15'h0008);
        wr(IEP_IDX_MAIN_EN, 8'h02);
        expect_none();
        wr(IEP_IDX_MAIN_EN, 8'h80);
        expect_none();
        wr(IEP_IDX_MAIN_EN, 8'h82);
        expect_take(4'd3, 2'd0);
        flags(15'h0000);
        ret();
    endtask : t_gate

    task automatic t_each();
        logic [7:0] en;
        for (int s = 0; s < 15; s++) begin
            en = 8'h01 << pos[s][2:0];
            wr(IEP_IDX_AUX_EN, pos[s][4] ? en : 8'h00);
            wr(IEP_IDX_MAIN_EN, pos[s][4] ? 8'h80 : (8'h80 | en));
            flags(15'h0001 << s);
            expect_take(s[3:0], 2'd0);
            flags(15'h0000);
            ret();
        end
    endtask : t_each

    task automatic t_prio();
        ack_wait <= 4'h2;
        wr(IEP_IDX_PRIO_HI_AUX, 8'h40);
        wr(IEP_IDX_PRIO_LO_AUX, 8'h80);
        wr(IEP_IDX_MAIN_EN, 8'hFF);
        wr(IEP_IDX_AUX_EN, 8'hFF);
        flags(15'h7FFF);
        expect_take(4'd14, 2'd2);
        wr(IEP_IDX_PRIO_LO_MAIN, 8'h10);
        wr(IEP_IDX_PRIO_HI_MAIN, 8'h10);
        expect_take(4'd12, 2'd3);
        expect_none();
        rchk(IEP_IDX_STATUS, 32'h0000_0C78, 1'b0);
        // Uart must stop asking, else it rightly preempts level 2 again
        flags(15'h6FFF);
        ret();
        expect_none();
        ret();
        expect_take(4'd14, 2'd2);
        flags(15'h7FFF);
        expect_take(4'd12, 2'd3);
        flags(15'h0000);
        ret();
        ret();
        wr(IEP_IDX_PRIO_HI_MAIN, 8'h00);
        wr(IEP_IDX_PRIO_LO_MAIN, 8'h00);
        wr(IEP_IDX_PRIO_HI_AUX, 8'h00);
        wr(IEP_IDX_PRIO_LO_AUX, 8'h00);
        flags(15'h7FFF);
        expect_take(4'd0, 2'd0);
        flags(15'h0000);
        ret();
    endtask : t_prio

    task automatic t_reset();
        wr(IEP_IDX_MAIN_EN, 8'hFF);
        wr(IEP_IDX_AUX_EN, 8'h5A);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rchk(IEP_IDX_MAIN_EN, 32'h0, 1'b0);
        rchk(IEP_IDX_AUX_EN, 32'h0, 1'b0);
    endtask : t_reset

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // Whole run is a few hundred cycles; generous margin
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_gate();
        t_each();
        t_prio();
        t_reset();
        wrap_up();
    end
endmodule : interrupt_enable_priority_tb
